// >>> rtl/shared_pin_function_select.sv
// apb slave holding the shared pin select register and the pin muxes
// assumes apb master, all sources synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_map.svh"

// Functional notes
// - bit 6 picks refresh over chip select six
// - bit 5 picks timer2 over coprocessor handshake
// - bit 4 picks chip select five over ack0
// - bit 3 picks serial cts over end-of-process
// - bit 2 picks serial txd over ack1
// - bit 1 picks serial dtr over receive clock
// - bit 0 picks serial rts over sync transmit
module shared_pin_function_select
  import pin_select_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // per-pin default sources, index = select bit
  input wire logic [6:0] main_out,
  input wire logic [6:0] main_oe,
  // per-pin alternate sources, index = select bit
  input wire logic [6:0] alt_out,
  input wire logic [6:0] alt_oe,
  // pins
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe,
  // current selection
  output logic [7:0] shared_pin_select
);
  // register state and read data live in one struct
  select_reg_s r;
  select_reg_s next_r;
  // transfer decode
  logic hit;
  logic wr_acc;
  logic rd_setup;

  // decode
  assign hit = (paddr == `SHARED_PIN_SELECT_OFFSET);
  assign wr_acc = psel & penable & pwrite & hit & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // register update, bit 7 stored as written
  always_comb begin
    next_r = r;
    if (wr_acc) begin
      next_r.sel = pwdata[7:0];
    end
    // read data loaded in setup, stands through the access phase
    if (rd_setup) begin
      next_r.rdata = hit ? {24'h00_0000, r.sel} : 32'h0000_0000;
    end
  end

  // async reset to the chosen reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{sel: `SHARED_PIN_SELECT_RESET, rdata: 32'h0000_0000};
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign shared_pin_select = r.sel;

  // one mux per shared pin
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_pin
      pin_route_mux u_mux (
        .alt_sel(r.sel[gi]),
        .main_out(main_out[gi]),
        .main_oe(main_oe[gi]),
        .alt_out(alt_out[gi]),
        .alt_oe(alt_oe[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi])
      );
    end
  endgenerate

  // assertions
  property p_write_applies;
    @(posedge pclk) disable iff (!presetn)
      wr_acc |=> (shared_pin_select == $past(pwdata[7:0]));
  endproperty
  a_write_applies: assert property (p_write_applies)
    else $error("write not applied next cycle");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      !wr_acc |=> $stable(shared_pin_select);
  endproperty
  a_hold: assert property (p_hold)
    else $error("selection changed without write");

  sequence s_read_setup;
    psel & ~penable & ~pwrite & hit;
  endsequence
  property p_readback;
    @(posedge pclk) disable iff (!presetn)
      s_read_setup ##1 (psel & penable) |->
        prdata[7:0] == $past(shared_pin_select);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback mismatch");

  // refused access: error flagged, register left alone
  sequence s_unmapped_access;
    psel & penable & ~hit;
  endsequence
  property p_refuse;
    @(posedge pclk) disable iff (!presetn)
      s_unmapped_access |-> pslverr ##1 $stable(shared_pin_select);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("unmapped access not refused");

  // an unmapped read returns zero
  property p_unmapped_zero;
    @(posedge pclk) disable iff (!presetn)
      (rd_setup & ~hit) |=> (prdata == 32'h0000_0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  // read data stands past the access edge
  property p_data_stands;
    @(posedge pclk) disable iff (!presetn)
      (psel & penable) |=> $stable(prdata);
  endproperty
  a_data_stands: assert property (p_data_stands)
    else $error("read data moved after access");

  // a write with the low strobe clear leaves the selection alone
  property p_no_strobe;
    @(posedge pclk) disable iff (!presetn)
      (psel & penable & pwrite & ~pstrb[0]) |=>
        $stable(shared_pin_select);
  endproperty
  a_no_strobe: assert property (p_no_strobe)
    else $error("strobeless write changed selection");

  // lane 6: chip select six or refresh strobe
  property p_pin6;
    @(posedge pclk) disable iff (!presetn)
      shared_pin_select[`SEL_REFRESH_VS_CS_SIX_BIT] ?
        (pin_out[6] == alt_out[6]) && (pin_oe[6] == alt_oe[6]) :
        (pin_out[6] == main_out[6]) && (pin_oe[6] == main_oe[6]);
  endproperty
  a_pin6: assert property (p_pin6)
    else $error("pin 6 route wrong");

  // lane 5: coprocessor handshake or timer2 group
  property p_pin5;
    @(posedge pclk) disable iff (!presetn)
      shared_pin_select[`SEL_TIMER2_VS_COPROC_BIT] ?
        (pin_out[5] == alt_out[5]) && (pin_oe[5] == alt_oe[5]) :
        (pin_out[5] == main_out[5]) && (pin_oe[5] == main_oe[5]);
  endproperty
  a_pin5: assert property (p_pin5)
    else $error("pin 5 route wrong");

  // lane 4: channel 0 acknowledge or chip select five
  property p_pin4;
    @(posedge pclk) disable iff (!presetn)
      shared_pin_select[`SEL_CHAN0_ACK_VS_CS_FIVE_BIT] ?
        (pin_out[4] == alt_out[4]) && (pin_oe[4] == alt_oe[4]) :
        (pin_out[4] == main_out[4]) && (pin_oe[4] == main_oe[4]);
  endproperty
  a_pin4: assert property (p_pin4)
    else $error("pin 4 route wrong");

  // lane 3: end of process or serial clear to send
  property p_pin3;
    @(posedge pclk) disable iff (!presetn)
      shared_pin_select[`SEL_END_PROCESS_VS_SERIAL_CTS_BIT] ?
        (pin_out[3] == alt_out[3]) && (pin_oe[3] == alt_oe[3]) :
        (pin_out[3] == main_out[3]) && (pin_oe[3] == main_oe[3]);
  endproperty
  a_pin3: assert property (p_pin3)
    else $error("pin 3 route wrong");

  // lane 2: channel 1 acknowledge or serial transmit data
  property p_pin2;
    @(posedge pclk) disable iff (!presetn)
      shared_pin_select[`SEL_CHAN1_ACK_VS_SERIAL_TXD_BIT] ?
        (pin_out[2] == alt_out[2]) && (pin_oe[2] == alt_oe[2]) :
        (pin_out[2] == main_out[2]) && (pin_oe[2] == main_oe[2]);
  endproperty
  a_pin2: assert property (p_pin2)
    else $error("pin 2 route wrong");

  // lane 1: sync receive clock or serial terminal ready
  property p_pin1;
    @(posedge pclk) disable iff (!presetn)
      shared_pin_select[`SEL_SYNC_RXCLK_VS_SERIAL_DTR_BIT] ?
        (pin_out[1] == alt_out[1]) && (pin_oe[1] == alt_oe[1]) :
        (pin_out[1] == main_out[1]) && (pin_oe[1] == main_oe[1]);
  endproperty
  a_pin1: assert property (p_pin1)
    else $error("pin 1 route wrong");

  // lane 0: sync transmit or serial request to send
  property p_pin0;
    @(posedge pclk) disable iff (!presetn)
      shared_pin_select[`SEL_SYNC_TX_VS_SERIAL_RTS_BIT] ?
        (pin_out[0] == alt_out[0]) && (pin_oe[0] == alt_oe[0]) :
        (pin_out[0] == main_out[0]) && (pin_oe[0] == main_oe[0]);
  endproperty
  a_pin0: assert property (p_pin0)
    else $error("pin 0 route wrong");
endmodule : shared_pin_function_select
`default_nettype wire

// >>> rtl/pin_select_map.svh
// offsets, field positions and reset values of the shared pin select block
// assumes inclusion from package and modules by bare name
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH
`define SHARED_PIN_SELECT_OFFSET 12'h000
`define SHARED_PIN_SELECT_RESET 8'h00
`define SEL_SYNC_TX_VS_SERIAL_RTS_BIT 0
`define SEL_SYNC_RXCLK_VS_SERIAL_DTR_BIT 1
`define SEL_CHAN1_ACK_VS_SERIAL_TXD_BIT 2
`define SEL_END_PROCESS_VS_SERIAL_CTS_BIT 3
`define SEL_CHAN0_ACK_VS_CS_FIVE_BIT 4
`define SEL_TIMER2_VS_COPROC_BIT 5
`define SEL_REFRESH_VS_CS_SIX_BIT 6
`define SHARED_PIN_SELECT_WIDTH 8
`endif

// >>> rtl/pin_select_pkg.sv
// types of the shared pin select block
// assumes the map header is on the include path
package pin_select_pkg;
  typedef logic [7:0] select_t;
  typedef struct packed {
    select_t sel;
    logic [31:0] rdata;
  } select_reg_s;
endpackage : pin_select_pkg

// >>> rtl/pin_route_mux.sv
// one two-way choice between a default and an alternate pin driver
// assumes both sources are synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module pin_route_mux (
  // choice
  input wire logic alt_sel,
  // sources
  input wire logic main_out,
  input wire logic main_oe,
  input wire logic alt_out,
  input wire logic alt_oe,
  // pin
  output logic pin_out,
  output logic pin_oe
);
  // pick the driver
  assign pin_out = alt_sel ? alt_out : main_out;
  assign pin_oe = alt_sel ? alt_oe : main_oe;
endmodule : pin_route_mux
`default_nettype wire

// >>> verification/board_pins.sv
// board side: pulled-up shared package pins
// assumes pin drive and enable from the select block
`timescale 1ns/1ps
`default_nettype none
module board_pins (
  // pins
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  // level seen by the peripherals
  output logic [6:0] level
);
  // a released line floats high through its pull-up
  assign level = (pin_out & pin_oe) | ~pin_oe;
endmodule : board_pins
`default_nettype wire

// >>> verification/shared_pin_function_select_bench.sv
// bench: register access and pin routing of the select block
// assumes an apb slave with sources driven here
`timescale 1ns/1ps
`default_nettype none
module shared_pin_function_select_bench;
  import pin_select_pkg::*;
  typedef struct {logic [6:0] s, oe;} row_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic [6:0] mo = 7'h55, me = 7'h6b, ao = 7'h2a, ae = 7'h14;
  logic [6:0] po, pe, lv, xo;
  logic [7:0] sel;
  int n_fail = 0, comparisons = 0;
  row_s rows [6] = '{'{7'h00, 7'h6b}, '{7'h7f, 7'h14}, '{7'h01, 7'h6a},
    '{7'h40, 7'h2b}, '{7'h2a, 7'h41}, '{7'h55, 7'h3e}};
  shared_pin_function_select DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_out(mo), .main_oe(me), .alt_out(ao),
    .alt_oe(ae), .pin_out(po), .pin_oe(pe), .shared_pin_select(sel));
  board_pins board (.pin_out(po), .pin_oe(pe), .level(lv));
  // clock
  always #2 pclk = ~pclk;
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task complete_run;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // watchdog
  initial begin
    #20000;
    n_fail++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    chk("reset sel", 8'h00, sel);
    chk("reset pins", 7'(mo | ~me), lv);
    chk("reset oe", me, pe);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(1, 0, {25'h0, rows[i].s}, 4'h1);
      chk("wr err", 0, err);
      @(negedge pclk);
      xo = rows[i].s & ao | ~rows[i].s & mo;
      chk("sel", {1'b0, rows[i].s}, sel);
      chk("ready", 1, pready);
      chk("oe", rows[i].oe, pe);
      chk("out", xo, po);
      chk("pins", 7'(xo | ~rows[i].oe), lv);
      apb(0, 0, 0, 4'h0);
      chk("read", {25'h0, rows[i].s}, rd);
      $display("row %0d done", i);
    end
    apb(1, 12'h004, 32'h7f, 4'h1);
    chk("slverr", 1, err);
    apb(1, 0, 32'h7f, 4'h0);
    chk("no strobe err", 0, err);
    apb(0, 12'h008, 0, 4'h0);
    chk("unmapped", 0, rd);
    apb(0, 0, 0, 4'h0);
    chk("kept", 32'h55, rd);
    $display("refusal test done");
    @(posedge pclk);
    presetn <= 0;
    @(negedge pclk);
    chk("rereset", 8'h00, sel);
    chk("rereset read", 0, prdata);
    @(posedge pclk);
    presetn <= 1;
    apb(1, 0, 32'h0000_0041, 4'h1);
    apb(0, 0, 0, 4'h0);
    chk("after release", 32'h41, rd);
    chk("out after release", 7'(7'h41 & ao | ~7'h41 & mo), po);
    $display("reset test done");
    complete_run();
  end
endmodule : shared_pin_function_select_bench
`default_nettype wire
